// File: design/timer_pkg.sv
// holds the register map, field layout, reset values and types of the 16-bit timer
// assumes a 200 MHz system clock and a 32-bit Avalon-MM register bus
package timer_pkg;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_COUNT = 5'h00;
  localparam logic [4:0] OFF_CAPCMP_FIRST = 5'h04;
  localparam logic [4:0] OFF_CAPCMP_SECOND = 5'h08;
  localparam logic [4:0] OFF_MODE_CTRL = 5'h0C;
  localparam logic [4:0] OFF_CAPCMP_CTRL = 5'h10;
  localparam logic [4:0] OFF_IRQ_STATUS = 5'h14;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h18;

  // ****************************************
  // field positions
  // ****************************************
  localparam int MODE_OVF_BIT = 0;
  localparam int MODE_LO_BIT = 2;
  localparam int MODE_HI_BIT = 3;
  localparam int CTRL_W = 8;
  localparam int IRQ_W = 3;

  // ****************************************
  // reset values and count limits
  // ****************************************
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] CAPCMP_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_FREQ_MHZ = 200;
  localparam int COUNT_CLK_MHZ = 100;
  localparam int COUNT_DIV_DEF = CLK_FREQ_MHZ / COUNT_CLK_MHZ;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_STOP,
    MODE_EDGE_CLEAR,
    MODE_FREE,
    MODE_MATCH_CLEAR
  } op_mode_e;

  typedef enum logic [1:0] {
    EDGE_FALL,
    EDGE_RISE,
    EDGE_NONE,
    EDGE_BOTH
  } edge_sel_e;

  // capture/compare control register, bit 0 is first_cap
  typedef struct packed {
    edge_sel_e shared_edge;
    edge_sel_e first_edge;
    logic ext_count;
    logic pin_out;
    logic second_cap;
    logic first_cap;
  } capcmp_ctrl_s;

  // interrupt status and mask layout, bit 0 is match_first
  typedef struct packed {
    logic overflow;
    logic match_second;
    logic match_first;
  } irq_vec_s;

  function automatic op_mode_e decode_mode(input logic hi, input logic lo);
    case ({hi, lo})
      2'h0: return MODE_STOP;
      2'h1: return MODE_EDGE_CLEAR;
      2'h2: return MODE_FREE;
      2'h3: return MODE_MATCH_CLEAR;
      default: return MODE_STOP;
    endcase
  endfunction

endpackage

// File: design/edge_detect.sv
// holds the valid-edge detector for one timer input pin
// assumes the pin level is already synchronous to clock
`timescale 1ns/1ps
module edge_detect (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic level,
  input wire logic enable,
  input wire timer_pkg::edge_sel_e sel,
  output logic pulse
);
  import timer_pkg::*;

  logic prev_r;
  logic rise;
  logic fall;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prev_r <= 1'b0;
    end else if (ce) begin
      prev_r <= level;
    end
  end

  assign rise = level && !prev_r;
  assign fall = !level && prev_r;

  always_comb begin
    case (sel)
      EDGE_FALL: pulse = enable && fall;
      EDGE_RISE: pulse = enable && rise;
      EDGE_BOTH: pulse = enable && (rise || fall);
      default: pulse = 1'b0;
    endcase
  end

endmodule

// File: design/capcmp_unit.sv
// holds one 16-bit capture/compare register with its match detector
// assumes trig and tick are already gated by the run state
`timescale 1ns/1ps
module capcmp_unit #(
  parameter int W = 16
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic is_capture,
  input wire logic trig,
  input wire logic tick,
  input wire logic zero_blocked,
  input wire logic wr_en,
  input wire logic [W-1:0] count_val,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] value,
  output logic match
);
  import timer_pkg::*;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      value <= W'(CAPCMP_RST);
    end else if (ce) begin
      if (is_capture && trig) begin
        value <= count_val;
      end else if (wr_en) begin
        value <= wr_data;
      end
    end
  end

  // match fires as the count leaves the compare value
  assign match = tick && !is_capture && (count_val == value) &&
                 !(zero_blocked && (value == '0));

endmodule

// File: design/timer_capture_compare_16bit.sv
// holds the 16-bit timer/event counter with two capture/compare registers
// assumes an Avalon-MM master with waitrequest and pins synchronous to clock
`timescale 1ns/1ps

module timer_capture_compare_16bit #(
  parameter int COUNT_DIV = timer_pkg::COUNT_DIV_DEF
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [timer_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic edge_input_first,
  input wire logic shared_port_pin_in,
  output logic shared_port_pin_out,
  output logic shared_port_pin_oe,
  output logic irq
);
  import timer_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(COUNT_DIV - 1);

  logic [15:0] count_r;
  logic [DIV_W-1:0] div_r;
  logic tick_pend_r;
  logic waitrequest_r;
  logic [31:0] readdata_r;
  logic overflow_flag_r;
  logic op_mode_bit_lo_r;
  logic op_mode_bit_hi_r;
  capcmp_ctrl_s ctrl_r;
  irq_vec_s status_r;
  irq_vec_s mask_r;
  irq_vec_s status_nxt;
  irq_vec_s events;
  irq_vec_s w1c;
  logic irq_r;
  logic tout_r;
  logic pin_out_r;
  logic pin_oe_r;

  op_mode_e mode;
  logic running;
  logic wr_acc;
  logic rd_req;
  logic count_hold;
  logic div_tick;
  logic raw_tick;
  logic tick;
  logic edge_first;
  logic edge_shared;
  logic stopping;
  logic clear_hit;
  logic edge_clear;
  logic wrap;
  logic match_first;
  logic match_second;
  logic [15:0] capcmp_first;
  logic [15:0] capcmp_second;
  logic [31:0] rdata;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
    return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  // ****************************************
  // bus decode
  // ****************************************
  assign mode = decode_mode(op_mode_bit_hi_r, op_mode_bit_lo_r);
  assign running = (mode != MODE_STOP);
  assign wr_acc = write && !waitrequest_r;
  assign rd_req = read && waitrequest_r;
  assign count_hold = rd_req && hit(address, OFF_COUNT);
  assign stopping = wr_acc && hit(address, OFF_MODE_CTRL) && byteenable[0] && running &&
                    !writedata[MODE_LO_BIT] && !writedata[MODE_HI_BIT];

  // ****************************************
  // count clock
  // ****************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= '0;
    end else if (ce) begin
      if (!running || div_r == DIV_LAST) begin
        div_r <= '0;
      end else begin
        div_r <= div_r + DIV_W'(1);
      end
    end
  end

  assign div_tick = running && (div_r == DIV_LAST);
  assign raw_tick = running && (ctrl_r.ext_count ? edge_first : div_tick);
  assign tick = running && !count_hold && (raw_tick || tick_pend_r);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tick_pend_r <= 1'b0;
    end else if (ce) begin
      if (!running) begin
        tick_pend_r <= 1'b0;
      end else if (count_hold) begin
        tick_pend_r <= tick_pend_r || raw_tick;
      end else begin
        tick_pend_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // input edges
  // ****************************************
  edge_detect u_edge_first (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .level(edge_input_first),
    .enable(running),
    .sel(ctrl_r.first_edge),
    .pulse(edge_first)
  );

  edge_detect u_edge_shared (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .level(shared_port_pin_in),
    .enable(running && !ctrl_r.pin_out),
    .sel(ctrl_r.shared_edge),
    .pulse(edge_shared)
  );

  // ****************************************
  // capture/compare registers
  // ****************************************
  capcmp_unit #(.W(16)) u_first (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .is_capture(ctrl_r.first_cap),
    .trig(edge_shared && !stopping),
    .tick(tick),
    .zero_blocked(mode == MODE_MATCH_CLEAR),
    .wr_en(wr_acc && hit(address, OFF_CAPCMP_FIRST)),
    .count_val(count_r),
    .wr_data(merge16(capcmp_first, writedata, byteenable)),
    .value(capcmp_first),
    .match(match_first)
  );

  capcmp_unit #(.W(16)) u_second (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .is_capture(ctrl_r.second_cap),
    .trig(edge_first && !stopping),
    .tick(tick),
    .zero_blocked(1'b0),
    .wr_en(wr_acc && hit(address, OFF_CAPCMP_SECOND)),
    .count_val(count_r),
    .wr_data(merge16(capcmp_second, writedata, byteenable)),
    .value(capcmp_second),
    .match(match_second)
  );

  // ****************************************
  // counter
  // ****************************************
  assign clear_hit = (mode == MODE_MATCH_CLEAR) && match_first;
  assign edge_clear = (mode == MODE_EDGE_CLEAR) && edge_first;
  assign wrap = tick && (count_r == COUNT_MAX) && !clear_hit && !edge_clear;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= COUNT_RST;
    end else if (ce) begin
      if (!running) begin
        count_r <= COUNT_RST;
      end else if (edge_clear) begin
        count_r <= COUNT_RST;
      end else if (tick) begin
        if (clear_hit) begin
          count_r <= COUNT_RST;
        end else begin
          count_r <= count_r + 16'h0001;
        end
      end
    end
  end

  // ****************************************
  // mode and control registers
  // ****************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      op_mode_bit_lo_r <= 1'b0;
      op_mode_bit_hi_r <= 1'b0;
    end else if (ce) begin
      if (wr_acc && hit(address, OFF_MODE_CTRL) && byteenable[0]) begin
        op_mode_bit_lo_r <= writedata[MODE_LO_BIT];
        op_mode_bit_hi_r <= writedata[MODE_HI_BIT];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      overflow_flag_r <= 1'b0;
    end else if (ce) begin
      if (wrap) begin
        overflow_flag_r <= 1'b1;
      end else if (wr_acc && hit(address, OFF_MODE_CTRL) && byteenable[0]) begin
        overflow_flag_r <= writedata[MODE_OVF_BIT];
      end
    end
  end

  // control is taken only while stopped
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= capcmp_ctrl_s'(CTRL_RST);
    end else if (ce) begin
      if (wr_acc && hit(address, OFF_CAPCMP_CTRL) && byteenable[0] && !running) begin
        ctrl_r <= capcmp_ctrl_s'(writedata[CTRL_W-1:0]);
      end
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  assign events = '{overflow: wrap, match_second: match_second, match_first: match_first};
  assign w1c = (wr_acc && hit(address, OFF_IRQ_STATUS) && byteenable[0]) ?
               irq_vec_s'(writedata[IRQ_W-1:0]) : irq_vec_s'('0);
  assign status_nxt = (status_r & ~w1c) | events;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= '0;
      irq_r <= 1'b0;
    end else if (ce) begin
      status_r <= status_nxt;
      irq_r <= |(status_nxt & mask_r);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mask_r <= irq_vec_s'(MASK_RST);
    end else if (ce) begin
      if (wr_acc && hit(address, OFF_IRQ_MASK) && byteenable[0]) begin
        mask_r <= irq_vec_s'(writedata[IRQ_W-1:0]);
      end
    end
  end

  // ****************************************
  // timer output on the shared pin
  // ****************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tout_r <= 1'b0;
    end else if (ce) begin
      if (!running) begin
        tout_r <= 1'b0;
      end else if (match_first || match_second) begin
        tout_r <= !tout_r;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_out_r <= 1'b0;
      pin_oe_r <= 1'b0;
    end else if (ce) begin
      pin_out_r <= ctrl_r.pin_out && tout_r;
      pin_oe_r <= ctrl_r.pin_out;
    end
  end

  // ****************************************
  // read path and bus handshake
  // ****************************************
  always_comb begin
    rdata = '0;
    case (address)
      OFF_COUNT: rdata[15:0] = count_r;
      OFF_CAPCMP_FIRST: rdata[15:0] = capcmp_first;
      OFF_CAPCMP_SECOND: rdata[15:0] = capcmp_second;
      OFF_MODE_CTRL: begin
        rdata[MODE_OVF_BIT] = overflow_flag_r;
        rdata[MODE_LO_BIT] = op_mode_bit_lo_r;
        rdata[MODE_HI_BIT] = op_mode_bit_hi_r;
      end
      OFF_CAPCMP_CTRL: rdata[CTRL_W-1:0] = ctrl_r;
      OFF_IRQ_STATUS: rdata[IRQ_W-1:0] = status_r;
      OFF_IRQ_MASK: rdata[IRQ_W-1:0] = mask_r;
      default: rdata = '0;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      waitrequest_r <= 1'b1;
      readdata_r <= '0;
    end else if (ce) begin
      if (!waitrequest_r) begin
        waitrequest_r <= 1'b1;
      end else if (read || write) begin
        waitrequest_r <= 1'b0;
      end
      if (rd_req) begin
        readdata_r <= rdata;
      end
    end
  end

  assign readdata = readdata_r;
  assign waitrequest = waitrequest_r;
  assign shared_port_pin_out = pin_out_r;
  assign shared_port_pin_oe = pin_oe_r;
  assign irq = irq_r;

endmodule

// File: tb/timer_pin_model.sv
// pin model: clean pulses on the two timer input pins
// assumes fire requests come from the bench on the rising clock edge
`timescale 1ns/1ps
module timer_pin_model (
  input wire logic clock,
  input wire logic fire_first,
  input wire logic fire_shared,
  input wire logic pin_oe,
  input wire logic pin_out,
  output logic edge_input_first,
  output logic shared_port_pin_in
);
  logic [2:0] len_a = 3'h0;
  logic [2:0] len_b = 3'h0;
  // pulses stay high six cycles, longer than two count clocks
  always @(posedge clock) begin
    len_a <= fire_first ? 3'h6 : len_a - 3'(len_a != 3'h0);
    len_b <= fire_shared ? 3'h6 : len_b - 3'(len_b != 3'h0);
  end
  assign edge_input_first = len_a != 3'h0;
  // shared wire: block output wins while enabled, else model level on pull-down
  assign shared_port_pin_in = pin_oe ? pin_out : (len_b != 3'h0);
endmodule

// File: tb/timer_capture_compare_16bit_assertions.sv
// checker of bus handshake, stop state and interrupt gating
// assumes ce held high; bound to the timer top module
`timescale 1ns/1ps
module timer_capture_compare_16bit_checker (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [timer_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic irq
);
  import timer_pkg::*;
  logic [1:0] mode_r;
  logic [IRQ_W-1:0] mask_r;
  logic [1:0] idle_r;
  wire logic acc = write && !waitrequest && byteenable[0];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= 2'h0;
      mask_r <= MASK_RST;
    end else if (acc && address == OFF_MODE_CTRL) begin
      mode_r <= writedata[MODE_HI_BIT:MODE_LO_BIT];
    end else if (acc && address == OFF_IRQ_MASK) begin
      mask_r <= writedata[IRQ_W-1:0];
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      idle_r <= 2'h0;
    end else if (mode_r != 2'h0) begin
      idle_r <= 2'h0;
    end else if (idle_r != 2'h3) begin
      idle_r <= idle_r + 2'h1;
    end
  end
  wait_pulse_a: assert property ($fell(waitrequest) |=> waitrequest)
    else $error("waitrequest low too long");
  wait_answer_a: assert property ((read || write) && waitrequest && ce |=> !waitrequest)
    else $error("no answer one cycle after request");
  wait_cause_a: assert property ($fell(waitrequest) |-> $past(read || write))
    else $error("answer without request");
  upper_zero_a: assert property (read && !waitrequest |-> readdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  unmapped_zero_a: assert property (read && waitrequest && address == 5'h1C
    |=> readdata == 32'h00000000) else $error("unmapped read not zero");
  stop_count_a: assert property (read && !waitrequest && address == OFF_COUNT
    && idle_r == 2'h3 |-> readdata[15:0] == COUNT_RST) else $error("count moves when stopped");
  stop_irq_a: assert property (idle_r == 2'h3 && mask_r == $past(mask_r, 2)
    |-> !$rose(irq)) else $error("interrupt while stopped");
  mask_off_a: assert property (mask_r == 3'h0 && $past(mask_r) == 3'h0 |-> !irq)
    else $error("interrupt with all masked");
endmodule
bind timer_capture_compare_16bit timer_capture_compare_16bit_checker checker_i (
  .clock(clock), .reset_n(reset_n), .ce(ce), .address(address), .read(read),
  .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .irq(irq)
);

// File: tb/timer_capture_compare_16bit_tb.sv
// self-checking bench of the timer through its bus and pins
// assumes timer_pin_model on the pins and the bound checker
`timescale 1ns/1ps
module timer_capture_compare_16bit_tb;
  import timer_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [ADDR_W-1:0] address = 5'h00;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd, c0, c1;
  logic waitrequest, edge_input_first, pin_in, pin_out, pin_oe, irq;
  logic fire_first = 1'b0;
  logic fire_shared = 1'b0;
  int n_errors = 0;
  int checked = 0;
  always #2.5 clock = ~clock;
  timer_capture_compare_16bit #(.COUNT_DIV(2)) timer_capture_compare_16bit_i (
    .clock(clock), .reset_n(reset_n), .ce(1'b1), .address(address), .read(read),
    .write(write), .byteenable(4'hF), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .edge_input_first(edge_input_first),
    .shared_port_pin_in(pin_in), .shared_port_pin_out(pin_out),
    .shared_port_pin_oe(pin_oe), .irq(irq));
  timer_pin_model timer_pin_model_i (.clock(clock), .fire_first(fire_first),
    .fire_shared(fire_shared), .pin_oe(pin_oe), .pin_out(pin_out),
    .edge_input_first(edge_input_first), .shared_port_pin_in(pin_in));
  // ****************************************
  // tasks
  // ****************************************
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    for (i = 0; i < 20 && waitrequest !== 1'b0; i++) begin
      @(posedge clock);
    end
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (i == 20) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic pulse(input logic sh);
    @(posedge clock);
    fire_first <= ~sh;
    fire_shared <= sh;
    @(posedge clock);
    fire_first <= 1'b0;
    fire_shared <= 1'b0;
    repeat (12) @(posedge clock);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_reset();
    logic [4:0] offs [8];
    offs = '{OFF_COUNT, OFF_CAPCMP_FIRST, OFF_CAPCMP_SECOND, OFF_MODE_CTRL,
      OFF_CAPCMP_CTRL, OFF_IRQ_STATUS, OFF_IRQ_MASK, 5'h1C};
    foreach (offs[i]) begin
      rdc(offs[i], 32'h0);
    end
  endtask
  task automatic s_stopped();
    wr(OFF_IRQ_MASK, 32'h7);
    wr(OFF_CAPCMP_CTRL, 32'hF3);
    pulse(1'b0);
    pulse(1'b1);
    rdc(OFF_COUNT, 32'h0);
    rdc(OFF_IRQ_STATUS, 32'h0);
    check(irq, 1'b0);
    wr(OFF_IRQ_MASK, 32'h0);
  endtask
  task automatic s_run();
    wr(OFF_CAPCMP_CTRL, 32'hA2);
    wr(OFF_MODE_CTRL, 32'h8);
    bus(1'b0, OFF_COUNT, 32'h0);
    c0 = rd;
    for (int k = 0; k < 4; k++) begin
      repeat (5) @(posedge clock);
      bus(1'b0, OFF_COUNT, 32'h0);
      check(rd - c0, 32'h4);
      c0 = rd;
    end
    rdc(OFF_CAPCMP_SECOND, 32'h0);
    wr(OFF_MODE_CTRL, 32'h0);
    repeat (3) @(posedge clock);
    rdc(OFF_COUNT, 32'h0);
  endtask
  task automatic s_capture();
    wr(OFF_CAPCMP_FIRST, 32'hFFFF);
    wr(OFF_CAPCMP_CTRL, 32'h52);
    wr(OFF_MODE_CTRL, 32'h8);
    bus(1'b0, OFF_COUNT, 32'h0);
    c0 = rd;
    pulse(1'b0);
    bus(1'b0, OFF_CAPCMP_SECOND, 32'h0);
    c1 = rd;
    bus(1'b0, OFF_COUNT, 32'h0);
    check(32'(c1 > c0 && c1 < rd), 32'h1);
    pulse(1'b1);
    rdc(OFF_CAPCMP_FIRST, 32'hFFFF);
    check(pin_oe, 1'b0);
    wr(OFF_MODE_CTRL, 32'h0);
  endtask
  task automatic s_pin();
    wr(OFF_CAPCMP_CTRL, 32'h45);
    wr(OFF_MODE_CTRL, 32'h8);
    bus(1'b0, OFF_CAPCMP_FIRST, 32'h0);
    c0 = rd;
    pulse(1'b1);
    rdc(OFF_CAPCMP_FIRST, c0);
    check(pin_oe, 1'b1);
    check(pin_out, 1'b1);
    wr(OFF_MODE_CTRL, 32'h0);
  endtask
  task automatic s_match();
    int i;
    wr(OFF_CAPCMP_CTRL, 32'hA0);
    wr(OFF_CAPCMP_FIRST, 32'h0);
    wr(OFF_CAPCMP_SECOND, 32'hFFF0);
    wr(OFF_IRQ_STATUS, 32'h7);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_MODE_CTRL, 32'hC);
    repeat (80) @(posedge clock);
    rdc(OFF_IRQ_STATUS, 32'h0);
    wr(OFF_MODE_CTRL, 32'h0);
    wr(OFF_CAPCMP_FIRST, 32'h10);
    wr(OFF_MODE_CTRL, 32'hC);
    for (i = 0; i < 100 && irq !== 1'b1; i++) begin
      @(posedge clock);
    end
    check(irq, 1'b1);
    if (i == 100) begin
      report_and_stop();
    end
    wr(OFF_MODE_CTRL, 32'h0);
    rdc(OFF_IRQ_STATUS, 32'h1);
    wr(OFF_IRQ_MASK, 32'h0);
    wr(OFF_CAPCMP_FIRST, 32'hFFF0);
    wr(OFF_IRQ_STATUS, 32'h7);
    wr(OFF_MODE_CTRL, 32'h8);
    repeat (80) @(posedge clock);
    wr(OFF_CAPCMP_FIRST, 32'h5);
    repeat (100) @(posedge clock);
    rdc(OFF_IRQ_STATUS, 32'h0);
    wr(OFF_MODE_CTRL, 32'h0);
  endtask
  task automatic s_ext();
    wr(OFF_CAPCMP_CTRL, 32'h1A);
    wr(OFF_MODE_CTRL, 32'h8);
    repeat (3) pulse(1'b0);
    rdc(OFF_COUNT, 32'h3);
    rdc(OFF_CAPCMP_SECOND, 32'h2);
    wr(OFF_MODE_CTRL, 32'h0);
    wr(OFF_CAPCMP_CTRL, 32'h12);
    wr(OFF_MODE_CTRL, 32'h4);
    repeat (40) @(posedge clock);
    pulse(1'b0);
    bus(1'b0, OFF_CAPCMP_SECOND, 32'h0);
    c1 = rd;
    bus(1'b0, OFF_COUNT, 32'h0);
    check(32'(rd < 32'h10 && c1 > 32'h10), 32'h1);
    wr(OFF_MODE_CTRL, 32'h0);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    s_reset();
    s_stopped();
    s_run();
    s_capture();
    s_pin();
    s_match();
    s_ext();
    report_and_stop();
  end
endmodule
